//--- verilog/nvc_ctrl.sv
`include "nvc_consts.svh"
module nvc_ctrl #(
   parameter int ATOMIC_CYC = `NVC_ATOMIC_CYC,
   parameter int SPLIT_CYC = `NVC_SPLIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rd_control,
   output logic [7:0] o_rd_data,
   output logic [7:0] o_rd_addr_low,
   output logic [7:0] o_rd_addr_high,
   output logic o_ready_irq,
   output logic o_stall
);
   // all block state in one word, so reset and next-state logic stay in one place
   typedef struct packed {
      nvc_pkg::nvc_state_t st;
      logic [8:0] addr;
      logic [7:0] data;
      nvc_pkg::nvc_action_t act;
      logic irq_en;
      logic arm;
      logic [2:0] arm_cnt;
      logic go;
      logic [2:0] stall_cnt;
      logic [22:0] timer;
      logic mem_we;
      logic irq;
   } nvc_state_s_t;

   nvc_state_s_t s_q, s_d;
   logic [7:0] mem_rdata;
   logic [7:0] ctl_wr;

   function automatic logic [22:0] prog_time(input nvc_pkg::nvc_action_t a);
      // erase+write takes the long time, the split actions the short one
      // the timer runs down to zero, so it is loaded one short of the length
      if (a == nvc_pkg::NVC_ERASE_WRITE) begin
         prog_time = 23'(ATOMIC_CYC - 1);
      end else begin
         prog_time = 23'(SPLIT_CYC - 1);
      end
   endfunction

   // counters stop at zero rather than wrapping
   function automatic logic [2:0] dec3(input logic [2:0] c);
      if (c == 3'h0) begin
         dec3 = 3'h0;
      end else begin
         dec3 = c - 3'h1;
      end
   endfunction

   // (RULE12) reset spares a running action
   function automatic nvc_state_s_t apply_reset(input nvc_state_s_t n, input logic running);
      apply_reset = n;
      apply_reset.irq_en = 1'b0;
      apply_reset.arm = 1'b0;
      apply_reset.arm_cnt = 3'h0;
      apply_reset.stall_cnt = 3'h0;
      // a cut action would leave the cell half written
      if (running) begin
         // timer, action and the byte being programmed must survive
         apply_reset.act = n.act;
      end else begin
         apply_reset.st = nvc_pkg::NVC_IDLE;
         apply_reset.go = 1'b0;
         apply_reset.timer = 23'h0;
         // (RULE9) field back to atomic
         apply_reset.act = nvc_pkg::NVC_ERASE_WRITE;
         apply_reset.mem_we = 1'b0;
         apply_reset.data = 8'h00;
      end
      apply_reset.irq = 1'b0;
   endfunction

   // control readback; the read strobe is a trigger, so bit 0 reads zero
   function automatic logic [7:0] ctl_image(input nvc_state_s_t s);
      ctl_image = {2'h0, s.act, s.irq_en, s.arm, s.go, 1'b0};
   endfunction

   // high address readback holds only bit 8
   function automatic logic [7:0] addr_high_image(input logic [8:0] a);
      addr_high_image = {7'h00, a[8]};
   endfunction

   // (RULE4) programmed byte from data
   // cell array; its read data come out of a register, one edge late
   nvc_mem #(.DEPTH(`NVC_DEPTH), .AW(9)) u_mem (
      .i_clk(i_clk),
      .i_we(s_q.mem_we),
      // (RULE6) action decode
      .i_erase(s_q.act == nvc_pkg::NVC_ERASE_ONLY),
      .i_wr_only(s_q.act == nvc_pkg::NVC_WRITE_ONLY),
      .i_addr(s_q.addr),
      .i_wdata(s_q.data),
      .o_rdata(mem_rdata)
   );

   // control write image, decoded field by field below
   assign ctl_wr = i_wdata;

   always_comb begin
      s_d = s_q;
      s_d.mem_we = 1'b0;
      // the core only sees the stall level; the count runs down by itself
      s_d.stall_cnt = dec3(s_q.stall_cnt);

      // a new arm write below restarts the window and wins over this clear
      // (RULE15) arm self clears
      if (s_q.arm) begin
         if (s_q.arm_cnt == 3'h1) begin
            s_d.arm = 1'b0;
         end
         s_d.arm_cnt = dec3(s_q.arm_cnt);
      end

      case (s_q.st)
         nvc_pkg::NVC_IDLE: begin
         end
         nvc_pkg::NVC_READ: begin
            // memory output is registered, so data lands one edge after the strobe
            // (RULE5) read data lands
            s_d.data = mem_rdata;
            s_d.st = nvc_pkg::NVC_IDLE;
         end
         nvc_pkg::NVC_PROG: begin
            // (RULE16) go held until time
            if (s_q.timer == 23'h0) begin
               s_d.go = 1'b0;
               // one write pulse after the busy time; the reserved action writes nothing
               s_d.mem_we = (s_q.act != nvc_pkg::NVC_RESERVED);
               s_d.st = nvc_pkg::NVC_IDLE;
            end else begin
               s_d.timer = s_q.timer - 23'h1;
            end
         end
         default: begin
            s_d.st = nvc_pkg::NVC_IDLE;
         end
      endcase

      if (i_wr) begin
         case (i_addr)
            `NVC_OFS_CONTROL: begin
               // (RULE10) enable stays writable while busy
               s_d.irq_en = ctl_wr[`NVC_BIT_IRQ_EN];
               // (RULE8) field locked while go
               if (!s_q.go) begin
                  s_d.act = nvc_pkg::nvc_action_t'(ctl_wr[`NVC_BIT_ACT_HI:`NVC_BIT_ACT_LO]);
               end
               if (ctl_wr[`NVC_BIT_ARM] && !s_q.go) begin
                  s_d.arm = 1'b1;
                  s_d.arm_cnt = `NVC_ARM_CYCLES;
               end
               // go takes precedence over a read strobe in the same write
               // (RULE15) go needs live arm
               if (ctl_wr[`NVC_BIT_GO] && s_q.arm && !s_q.go) begin
                  s_d.go = 1'b1;
                  s_d.arm = 1'b0;
                  s_d.st = nvc_pkg::NVC_PROG;
                  // (RULE7) programming time
                  s_d.timer = prog_time(s_q.act);
                  // (RULE16) two cycle stall
                  s_d.stall_cnt = `NVC_GO_STALL;
               // (RULE18) no read while busy
               end else if (ctl_wr[`NVC_BIT_READ] && !s_q.go) begin
                  // (RULE17) four cycle stall
                  s_d.st = nvc_pkg::NVC_READ;
                  s_d.stall_cnt = `NVC_READ_STALL;
               end
            end
            `NVC_OFS_DATA: begin
               // data stays writable while busy; software leaves it alone until go clears
               s_d.data = i_wdata;
            end
            `NVC_OFS_ADDR_LOW: begin
               // a new address mid-action would retarget the pending write
               // (RULE18) address locked while busy
               if (!s_q.go) begin
                  s_d.addr[7:0] = i_wdata;
               end
            end
            `NVC_OFS_ADDR_HIGH: begin
               // (RULE1) address bit 8
               if (!s_q.go) begin
                  s_d.addr[8] = i_wdata[0];
               end
            end
            default: begin
            end
         endcase
      end

      // (RULE19) ready request
      s_d.irq = s_d.irq_en && !s_d.go;
      // reset is folded in last, so a busy action keeps its next-state values
      if (i_rst) begin
         s_d = apply_reset(s_d, s_q.go);
      end
   end

   // state registers; reset acts through s_d
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   // (RULE2) unused bits read zero
   // outputs mirror the next state, so a running action stays visible through reset
   always_ff @(posedge i_clk) begin
      o_rd_control <= ctl_image(s_d);
      o_rd_data <= s_d.data;
      // address is never reset, so its readback shows the held value
      o_rd_addr_low <= s_d.addr[7:0];
      o_rd_addr_high <= addr_high_image(s_d.addr);
      // (RULE11) level ready request
      o_ready_irq <= s_d.irq;
      o_stall <= (s_d.stall_cnt != 3'h0);
   end
endmodule

//--- shared/nvc_consts.svh
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH
// Behaviour
// (RULE1) byte address is high register bit 0 above all eight low register bits
// (RULE2) high address bits 7:1 and control bits 7:6 read as zero
// (RULE3) software loads a valid address before any read or programming action
// (RULE4) programming writes the data register byte at the selected address
// (RULE5) after a read strobe the data register holds the addressed byte
// (RULE6) action field 00 erase+write, 01 erase, 10 write, 11 reserved
// (RULE7) busy time 3.4 ms for erase+write, 1.8 ms for erase or write
// (RULE8) writes to the action field are ignored while go is set
// (RULE9) reset clears action field to 00 unless programming is under way
// (RULE10) ready interrupt enable bit 3 allows or disables the ready interrupt
// (RULE11) ready interrupt is a level while memory is ready and enabled
// (RULE12) reset does not abort a programming action in progress
// (RULE13) software waits go clear, sets field, address, data, arm, then go
// (RULE14) software waits go clear, loads address, strobes read, reads data
// (RULE15) go starts only within four cycles of arm; arm self-clears after four
// (RULE16) go stays set until access time elapses; core stalls two cycles
// (RULE17) read gives data at once; core stalls four cycles
// (RULE18) during programming read strobes and address writes are refused
// (RULE19) ready request is enable bit and go bit clear
`define NVC_OFS_CONTROL 2'h0
`define NVC_OFS_DATA 2'h1
`define NVC_OFS_ADDR_LOW 2'h2
`define NVC_OFS_ADDR_HIGH 2'h3
`define NVC_BIT_ACT_HI 5
`define NVC_BIT_ACT_LO 4
`define NVC_BIT_IRQ_EN 3
`define NVC_BIT_ARM 2
`define NVC_BIT_GO 1
`define NVC_BIT_READ 0
`define NVC_ARM_CYCLES 3'h4
`define NVC_GO_STALL 3'h2
`define NVC_READ_STALL 3'h4
`define NVC_CLK_KHZ 50000
`define NVC_ATOMIC_US 3400
`define NVC_SPLIT_US 1800
`define NVC_ATOMIC_CYC ((`NVC_ATOMIC_US * `NVC_CLK_KHZ) / 1000)
`define NVC_SPLIT_CYC ((`NVC_SPLIT_US * `NVC_CLK_KHZ) / 1000)
`define NVC_DEPTH 512
`endif

//--- shared/nvc_pkg.sv
package nvc_pkg;
   typedef enum logic [1:0] {NVC_ERASE_WRITE, NVC_ERASE_ONLY, NVC_WRITE_ONLY,
      NVC_RESERVED} nvc_action_t;
   typedef enum logic [1:0] {NVC_IDLE, NVC_READ, NVC_PROG} nvc_state_t;
endpackage

//--- verilog/nvc_mem.sv
module nvc_mem #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic i_erase,
   input wire logic i_wr_only,
   input wire logic [AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_q [DEPTH];
   // erase sets all ones; write-only can only clear bits, like a real cell
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         if (i_erase) begin
            mem_q[i_addr] <= 8'hff;
         end else if (i_wr_only) begin
            mem_q[i_addr] <= mem_q[i_addr] & i_wdata;
         end else begin
            mem_q[i_addr] <= i_wdata;
         end
      end
      o_rdata <= mem_q[i_addr];
   end
endmodule

//--- tb/nvc_ctrl_asserts.sv
module nvc_ctrl_asserts (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rd_control,
   input wire logic [7:0] o_rd_data,
   input wire logic [7:0] o_rd_addr_low,
   input wire logic [7:0] o_rd_addr_high,
   input wire logic o_ready_irq,
   input wire logic o_stall
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   wire go = o_rd_control[1];
   AST_IRQ: assert property (o_ready_irq == (o_rd_control[3] && !go))
      else $error("irq level");
   AST_ZERO: assert property (o_rd_addr_high[7:1] == 7'h00 && o_rd_control[7:6] == 2'h0)
      else $error("reserved bits");
   AST_ARM: assert property ($rose(o_rd_control[2]) |-> ##[1:5] !o_rd_control[2])
      else $error("arm stuck");
   AST_GO_STALL: assert property ($rose(go) |-> o_stall)
      else $error("no stall on go");
   AST_ACT: assert property (go && $past(go) |-> $stable(o_rd_control[5:4]))
      else $error("action changed");
   AST_ADDR: assert property (go && $past(go) |-> $stable(o_rd_addr_low))
      else $error("address changed");
   AST_RD_STALL: assert property (i_wr && i_addr == 2'h0 && i_wdata[0] && !go
      && !(i_wdata[1] && o_rd_control[2]) |=> o_stall[*4])
      else $error("read stall");
   AST_RST_ACT: assert property (disable iff (1'b0) i_rst && !go
      |=> o_rd_control[5:4] == 2'h0)
      else $error("action not reset");
   cover property ($fell(go));
   cover property (o_ready_irq);
   cover property (i_rst && go);
endmodule
bind nvc_ctrl nvc_ctrl_asserts u_asserts (.*);

//--- tb/nvc_cpu_model.sv
module nvc_cpu_model (
   input wire logic i_clk,
   input wire logic i_stall,
   output logic o_wr = 1'b0,
   output logic [1:0] o_addr = 2'h0,
   output logic [7:0] o_wdata = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // one write held for one cycle, at most every other cycle, held off while stalled
   task automatic put(input logic [1:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(negedge i_clk);
      while (i_stall !== 1'b0 && k < 8) begin
         @(negedge i_clk);
         k++;
      end
      if (k == 8) begin
         nvc_ctrl_tb_top.bad_count++;
         nvc_ctrl_tb_top.report_and_stop;
      end else begin
         o_wr = 1'b1;
         o_addr = a;
         o_wdata = d;
         @(negedge i_clk);
         o_wr = 1'b0;
      end
   endtask
endmodule

//--- tb/nvc_ctrl_tb_top.sv
module nvc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr, irq, stall;
   logic [1:0] ra;
   logic [7:0] wd, ctl, dat, al, ah;
   int bad_count = 0;
   int check_count = 0;
   int n;
   always #10 clk = ~clk;
   nvc_cpu_model u_cpu (.i_clk(clk), .i_stall(stall), .o_wr(wr), .o_addr(ra), .o_wdata(wd));
   nvc_ctrl #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) u_dut (.i_clk(clk), .i_rst(rst), .i_wr(wr),
      .i_addr(ra), .i_wdata(wd), .o_rd_control(ctl), .o_rd_data(dat), .o_rd_addr_low(al),
      .o_rd_addr_high(ah), .o_ready_irq(irq), .o_stall(stall));
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   task idle;
      n = 0;
      while (ctl[1] !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200) begin
         bad_count++;
         report_and_stop;
      end
   endtask
   // address loaded before arm and go
   task prog(input logic [1:0] m, input logic [8:0] ad, input logic [7:0] d);
      u_cpu.put(2'h0, {2'h0, m, 4'h0});
      u_cpu.put(2'h3, {7'h00, ad[8]});
      u_cpu.put(2'h2, ad[7:0]);
      u_cpu.put(2'h1, d);
      u_cpu.put(2'h0, {2'h0, m, 4'h4});
      u_cpu.put(2'h0, {2'h0, m, 4'h2});
   endtask
   task rd(input logic [8:0] ad);
      u_cpu.put(2'h3, {7'h00, ad[8]});
      u_cpu.put(2'h2, ad[7:0]);
      u_cpu.put(2'h0, 8'h01);
      repeat (5) @(negedge clk);
   endtask
   task t_modes;
      logic [7:0] wv [4] = '{8'h3c, 8'h00, 8'h5a, 8'h00};
      logic [7:0] ev [4] = '{8'h3c, 8'hff, 8'h5a, 8'h5a};
      int t;
      for (int m = 0; m < 4; m++) begin
         t = (m == 0) ? 20 : 10;
         prog(m[1:0], 9'h1a5, wv[m]);
         u_cpu.put(2'h0, 8'h30);
         u_cpu.put(2'h2, 8'h00);
         chk("action", 8'(m), {6'h0, ctl[5:4]});
         chk("addr", 8'ha5, al);
         idle;
         chk("busy", 8'h01, {7'h0, n >= t - 8 && n <= t - 2});
         rd(9'h1a5);
         chk("data", ev[m], dat);
      end
   endtask
   task t_arm;
      u_cpu.put(2'h0, 8'hc0);
      chk("ctl reserved", 8'h00, ctl);
      u_cpu.put(2'h0, 8'h02);
      chk("go no arm", 8'h00, ctl);
      u_cpu.put(2'h0, 8'h04);
      chk("arm set", 8'h04, ctl);
      repeat (6) @(negedge clk);
      chk("arm clear", 8'h00, ctl);
      u_cpu.put(2'h0, 8'h02);
      @(negedge clk);
      chk("late go", 8'h00, ctl);
   endtask
   task t_irq;
      u_cpu.put(2'h0, 8'h0c);
      u_cpu.put(2'h0, 8'h0a);
      @(negedge clk);
      chk("irq busy", 8'h00, {7'h0, irq});
      idle;
      @(negedge clk);
      chk("irq on", 8'h01, {7'h0, irq});
      u_cpu.put(2'h0, 8'h00);
      @(negedge clk);
      chk("irq off", 8'h00, {7'h0, irq});
   endtask
   task t_rst;
      prog(2'h1, 9'h0f0, 8'h00);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("ctl rst", 8'h12, ctl);
      idle;
      rd(9'h0f0);
      chk("erased", 8'hff, dat);
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk("ctl", 8'h00, ctl);
      u_cpu.put(2'h3, 8'hff);
      @(negedge clk);
      chk("addr high", 8'h01, ah);
      t_modes;
      t_arm;
      t_irq;
      t_rst;
      report_and_stop;
   end
endmodule
